// [rtl/lsm_consts.svh]
// Purpose: shared constants of the low-speed management link
// Assumes: 200 MHz core clock on both ends
// Notes: definitions only
`ifndef LSM_CONSTS_SVH
`define LSM_CONSTS_SVH
// timing, in ns as figures and cycles derived in the modules
`define LSM_CLK_NS 5
`define LSM_RST_MIN_NS 1000
`define LSM_INIT_NS 2000
// host serial clock quarter period in core cycles (80 ns bit)
`define LSM_HOST_QTR 4
// serial target address and memory map
`define LSM_DEV_ADDR 7'h50
`define LSM_MEM_DEPTH 16
`define LSM_STATUS_IDX 8'h00
`define LSM_CTRL_IDX 8'h01
// status byte fields
`define LSM_ST_DNR 0
`define LSM_ST_DONE 1
`define LSM_ST_FAULT 2
// control byte fields
`define LSM_CTRL_LP 0
`define LSM_CTRL_RST 8'h00
`endif

// [rtl/lsm_pkg.sv]
// Purpose: types of the low-speed management link
// Assumes: nothing
// Notes: constants live in lsm_consts.svh
package lsm_pkg;
  typedef enum logic [3:0] {
    LSM_D_IDLE, LSM_D_ADDR, LSM_D_AACK, LSM_D_REG, LSM_D_RACK,
    LSM_D_WR, LSM_D_WACK, LSM_D_RD, LSM_D_MACK, LSM_D_RDN
  } lsm_dev_st_t;
  typedef enum logic [1:0] {
    LSM_H_IDLE, LSM_H_START, LSM_H_BIT, LSM_H_STOP
  } lsm_host_st_t;
  typedef enum logic [2:0] {
    LSM_P_DEVW, LSM_P_REG, LSM_P_WDATA, LSM_P_DEVR, LSM_P_RDATA
  } lsm_host_ph_t;
endpackage

// [rtl/lsm_if.sv]
// Purpose: pins between host board and pluggable module
// Assumes: open-drain lines pulled high on the host board
// Notes: wire levels resolved here from drive enables
`timescale 1ns/100ps
interface lsm_if;
  logic host_scl_out, host_scl_oe;
  logic host_sda_out, host_sda_oe;
  logic dev_sda_out, dev_sda_oe;
  logic dev_present_out, dev_present_oe;
  logic dev_int_out, dev_int_oe;
  logic module_select_n, module_reset_n, low_power_select;
  logic scl, sda, module_present_n, interrupt_n;
  // pull-ups: a line reads low only while someone drives low
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) ||
                 (dev_sda_oe && !dev_sda_out));
  assign module_present_n = !(dev_present_oe && !dev_present_out);
  assign interrupt_n = !(dev_int_oe && !dev_int_out);
  modport dev_mp (
    input scl, sda, module_select_n, module_reset_n, low_power_select,
    output dev_sda_out, dev_sda_oe, dev_present_out, dev_present_oe,
    output dev_int_out, dev_int_oe
  );
  modport host_mp (
    input scl, sda, module_present_n, interrupt_n,
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
    output module_select_n, module_reset_n, low_power_select
  );
endinterface

// [rtl/lsm_device.sv]
// Purpose: module end of the low-speed management link
// Assumes: host makes the serial clock; pins sampled by CLK_IN
// Notes: serial target with a small byte memory map
// Function
// - answer serial bus only while selected
// - host drives one select line per module
// - long reset pulse restores all defaults
// - host ignores status until reset completes
// - completion: interrupt with not-ready bit clear
// - power-up raises completion interrupt unprompted
// - low-power input caps module power
// - module pulls presence line low
// - interrupt low flags fault or status
// - host reads cause over serial bus
// - interrupt is open collector, host pulls up
// - memory map reached over serial clock, data
`timescale 1ns/100ps
`include "lsm_consts.svh"
module lsm_device
  import lsm_pkg::*;
#(
  parameter int MEM_DEPTH = `LSM_MEM_DEPTH,
  parameter int RST_MIN_CYC =
    (`LSM_RST_MIN_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
  parameter int INIT_CYC = (`LSM_INIT_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  lsm_if.dev_mp LINK,
  input wire logic FAULT_IN,
  output logic READY_OUT,
  output logic POWER_HIGH_EN_OUT,
  output logic MOD_RESET_OUT
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int LW = $clog2(RST_MIN_CYC + 1);
  localparam int IW = $clog2(INIT_CYC + 1);

  // refuse shapes the logic cannot serve
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 ||
      (1 << AW) != MEM_DEPTH) begin : g_chk_mem
    $error("MEM_DEPTH must be a power of two from 2 to 256");
  end
  if (RST_MIN_CYC < 1 || INIT_CYC < 1) begin : g_chk_time
    $error("timing counts must be at least one cycle");
  end

  // pin synchronisers: scl, sda, select, reset, low power
  logic [4:0] meta_r, sync_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_r <= 5'h1F;
      sync_r <= 5'h1F;
    end else begin
      meta_r <= {LINK.scl, LINK.sda, LINK.module_select_n,
                 LINK.module_reset_n, LINK.low_power_select};
      sync_r <= meta_r;
    end
  end
  logic scl_s, sda_s, sel_n_s, mrst_n_s, lp_s;
  assign {scl_s, sda_s, sel_n_s, mrst_n_s, lp_s} = sync_r;

  // edge and bus condition detection on synced lines
  logic scl_d_r, sda_d_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  // reset filter, init sequence, status flags, power cap
  logic [LW-1:0] lo_cnt_r, lo_cnt_nxt;
  logic [IW-1:0] init_cnt_r, init_cnt_nxt;
  logic mr_act_r, mr_act_nxt, dnr_r, dnr_nxt, rdy_r, rdy_nxt;
  logic done_r, done_nxt, fault_r, fault_nxt, pw_r, pw_nxt;
  logic rd_stat, lp_ctrl;
  always_comb begin
    lo_cnt_nxt = '0;
    mr_act_nxt = 1'b0;
    if (!mrst_n_s) begin
      // only a low level held past the minimum counts
      if (lo_cnt_r == LW'(RST_MIN_CYC)) begin
        lo_cnt_nxt = lo_cnt_r;
        mr_act_nxt = 1'b1;
      end else begin
        lo_cnt_nxt = LW'(lo_cnt_r + 1'b1);
      end
    end
    init_cnt_nxt = init_cnt_r;
    dnr_nxt = dnr_r;
    done_nxt = done_r && !rd_stat;
    if (mr_act_r) begin
      init_cnt_nxt = '0;
      dnr_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (dnr_r) begin
      init_cnt_nxt = IW'(init_cnt_r + 1'b1);
      if (init_cnt_r == IW'(INIT_CYC - 1)) begin
        dnr_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
    // a new fault wins over a clear by status read
    fault_nxt = mr_act_r ? 1'b0 :
                ((FAULT_IN && !dnr_r) || (fault_r && !rd_stat));
    rdy_nxt = !dnr_nxt;
    pw_nxt = !lp_s && !lp_ctrl && !dnr_r && !mr_act_r;
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lo_cnt_r <= '0;
      init_cnt_r <= '0;
      mr_act_r <= 1'b0;
      dnr_r <= 1'b1;
      rdy_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      pw_r <= 1'b0;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
      init_cnt_r <= init_cnt_nxt;
      mr_act_r <= mr_act_nxt;
      dnr_r <= dnr_nxt;
      rdy_r <= rdy_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      pw_r <= pw_nxt;
    end
  end
  assign READY_OUT = rdy_r;
  assign POWER_HIGH_EN_OUT = pw_r;
  assign MOD_RESET_OUT = mr_act_r;

  // presence tie and open-collector interrupt
  assign LINK.dev_present_out = 1'b0;
  assign LINK.dev_present_oe = 1'b1;
  assign LINK.dev_int_out = 1'b0;
  assign LINK.dev_int_oe = done_r || fault_r;

  // serial target state
  lsm_dev_st_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] shf_r, shf_nxt, ptr_r, ptr_nxt;
  logic oe_r, oe_nxt, rw_r, rw_nxt;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] mem_nxt [MEM_DEPTH];
  assign lp_ctrl = mem_r[AW'(`LSM_CTRL_IDX)][`LSM_CTRL_LP];

  // byte seen by the host at a map index
  function automatic logic [7:0] rd_val(input logic [AW-1:0] idx);
    logic [7:0] v;
    v = mem_r[idx];
    if (idx == AW'(`LSM_STATUS_IDX)) begin
      v = 8'h00;
      v[`LSM_ST_DNR] = dnr_r;
      v[`LSM_ST_DONE] = done_r;
      v[`LSM_ST_FAULT] = fault_r;
    end
    return v;
  endfunction

  // serial target next state
  always_comb begin
    logic [7:0] byte_in;
    logic [AW-1:0] idx;
    logic load;
    byte_in = {shf_r[6:0], sda_s};
    idx = ptr_r[AW-1:0];
    load = 1'b0;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shf_nxt = shf_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    mem_nxt = mem_r;
    rd_stat = 1'b0;
    if (mr_act_r) begin
      st_nxt = LSM_D_IDLE;
      oe_nxt = 1'b0;
      ptr_nxt = 8'h00;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_nxt[i] = 8'h00;
      end
      mem_nxt[AW'(`LSM_CTRL_IDX)] = `LSM_CTRL_RST;
    end else if (sel_n_s) begin
      st_nxt = LSM_D_IDLE;
      oe_nxt = 1'b0;
    end else if (start_c) begin
      st_nxt = LSM_D_ADDR;
      cnt_nxt = 3'h0;
      oe_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = LSM_D_IDLE;
      oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        LSM_D_IDLE: begin
        end
        LSM_D_ADDR, LSM_D_REG, LSM_D_WR: begin
          if (scl_rise) begin
            shf_nxt = byte_in;
            cnt_nxt = 3'(cnt_r + 3'h1);
            if (cnt_r == 3'h7) begin
              if (st_r == LSM_D_ADDR) begin
                rw_nxt = byte_in[0];
                st_nxt = (byte_in[7:1] == `LSM_DEV_ADDR) ?
                         LSM_D_AACK : LSM_D_IDLE;
              end else if (st_r == LSM_D_REG) begin
                ptr_nxt = byte_in;
                st_nxt = LSM_D_RACK;
              end else begin
                if (idx != AW'(`LSM_STATUS_IDX)) begin
                  mem_nxt[idx] = byte_in;
                end
                ptr_nxt = ptr_r + 8'h01;
                st_nxt = LSM_D_WACK;
              end
            end
          end
        end
        LSM_D_AACK, LSM_D_RACK, LSM_D_WACK: begin
          if (scl_fall) begin
            if (!oe_r) begin
              oe_nxt = 1'b1; // acknowledge low
            end else if (st_r == LSM_D_AACK && rw_r) begin
              load = 1'b1;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = (st_r == LSM_D_AACK) ? LSM_D_REG : LSM_D_WR;
            end
          end
        end
        LSM_D_RD: begin
          if (scl_rise) begin
            cnt_nxt = 3'(cnt_r + 3'h1);
            if (cnt_r == 3'h7) begin
              st_nxt = LSM_D_MACK;
            end
          end else if (scl_fall) begin
            shf_nxt = {shf_r[6:0], 1'b0};
            oe_nxt = !shf_r[6];
          end
        end
        LSM_D_MACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
          end else if (scl_rise) begin
            st_nxt = sda_s ? LSM_D_IDLE : LSM_D_RDN;
          end
        end
        LSM_D_RDN: begin
          if (scl_fall) begin
            load = 1'b1;
          end
        end
      endcase
    end
    // put the next map byte on the line, msb first
    if (load) begin
      shf_nxt = rd_val(idx);
      oe_nxt = !shf_nxt[7];
      ptr_nxt = ptr_r + 8'h01;
      cnt_nxt = 3'h0;
      st_nxt = LSM_D_RD;
      rd_stat = (idx == AW'(`LSM_STATUS_IDX));
    end
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= LSM_D_IDLE;
      cnt_r <= 3'h0;
      shf_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shf_r <= shf_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      mem_r <= mem_nxt;
    end
  end
  assign LINK.dev_sda_out = 1'b0;
  assign LINK.dev_sda_oe = oe_r;
endmodule

// [rtl/lsm_host.sv]
// Purpose: host end of the low-speed management link
// Assumes: one module per select line; single byte per command
// Notes: makes the serial clock by dividing CLK_IN
`timescale 1ns/100ps
`include "lsm_consts.svh"
module lsm_host
  import lsm_pkg::*;
#(
  parameter int QTR_CYC = `LSM_HOST_QTR
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  lsm_if.host_mp LINK,
  input wire logic CMD_REQ_IN,
  input wire logic CMD_WR_IN,
  input wire logic [7:0] CMD_ADDR_IN,
  input wire logic [7:0] CMD_WDATA_IN,
  output logic CMD_BUSY_OUT,
  output logic CMD_DONE_OUT,
  output logic CMD_NACK_OUT,
  output logic [7:0] CMD_RDATA_OUT,
  input wire logic SELECT_IN,
  input wire logic RESET_REQ_IN,
  input wire logic LOW_POWER_IN,
  output logic PRESENT_OUT,
  output logic IRQ_OUT,
  output logic STATUS_VALID_OUT
);
  localparam int DW = $clog2(QTR_CYC + 1);
  if (QTR_CYC < 3) begin : g_chk_qtr
    $error("QTR_CYC must leave the module time to sample");
  end

  // pin synchronisers: sda, presence, interrupt
  logic [2:0] meta_r, sync_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
    end else begin
      meta_r <= {LINK.sda, LINK.module_present_n, LINK.interrupt_n};
      sync_r <= meta_r;
    end
  end
  logic sda_s;
  assign sda_s = sync_r[2];

  // sideband pins and status gating
  lsm_host_st_t st_r, st_nxt;
  logic sel_n_r, sel_n_nxt, mrst_n_r, mrst_n_nxt, lp_r, lp_nxt;
  logic pres_r, pres_nxt, irq_r, irq_nxt, valid_r, valid_nxt;
  always_comb begin
    sel_n_nxt = !(SELECT_IN || st_r != LSM_H_IDLE);
    mrst_n_nxt = !RESET_REQ_IN;
    lp_nxt = LOW_POWER_IN;
    pres_nxt = !sync_r[1];
    irq_nxt = !sync_r[0];
    valid_nxt = RESET_REQ_IN ? 1'b0 : (valid_r || irq_r);
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sel_n_r <= 1'b1;
      mrst_n_r <= 1'b1;
      lp_r <= 1'b1;
      pres_r <= 1'b0;
      irq_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      sel_n_r <= sel_n_nxt;
      mrst_n_r <= mrst_n_nxt;
      lp_r <= lp_nxt;
      pres_r <= pres_nxt;
      irq_r <= irq_nxt;
      valid_r <= valid_nxt;
    end
  end
  assign LINK.module_select_n = sel_n_r;
  assign LINK.module_reset_n = mrst_n_r;
  assign LINK.low_power_select = lp_r;
  assign PRESENT_OUT = pres_r;
  assign IRQ_OUT = irq_r;
  assign STATUS_VALID_OUT = valid_r;

  // serial controller state
  lsm_host_ph_t ph_r, ph_nxt;
  logic [DW-1:0] div_r, div_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shf_r, shf_nxt, addr_r, addr_nxt, wd_r, wd_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic wr_r, wr_nxt, scl_lo_r, scl_lo_nxt, sda_lo_r, sda_lo_nxt;
  logic nack_r, nack_nxt, done_r, done_nxt;
  always_comb begin
    logic tick;
    tick = (div_r == DW'(QTR_CYC - 1));
    st_nxt = st_r;
    ph_nxt = ph_r;
    div_nxt = tick ? '0 : DW'(div_r + 1'b1);
    q_nxt = tick ? 2'(q_r + 2'h1) : q_r;
    bit_nxt = bit_r;
    shf_nxt = shf_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    scl_lo_nxt = scl_lo_r;
    sda_lo_nxt = sda_lo_r;
    nack_nxt = nack_r;
    done_nxt = 1'b0;
    unique case (st_r)
      LSM_H_IDLE: begin
        div_nxt = '0;
        q_nxt = 2'h0;
        if (CMD_REQ_IN) begin
          st_nxt = LSM_H_START;
          ph_nxt = LSM_P_DEVW;
          wr_nxt = CMD_WR_IN;
          addr_nxt = CMD_ADDR_IN;
          wd_nxt = CMD_WDATA_IN;
          nack_nxt = 1'b0;
        end
      end
      LSM_H_START: if (tick) begin
        unique case (q_r)
          2'h0: begin
            scl_lo_nxt = 1'b1;
            sda_lo_nxt = 1'b0;
          end
          2'h1: scl_lo_nxt = 1'b0;
          2'h2: sda_lo_nxt = 1'b1;
          2'h3: begin
            scl_lo_nxt = 1'b1;
            st_nxt = LSM_H_BIT;
            bit_nxt = 4'h0;
            shf_nxt = {`LSM_DEV_ADDR, ph_r == LSM_P_DEVR};
          end
        endcase
      end
      LSM_H_BIT: if (tick) begin
        unique case (q_r)
          2'h0: begin
            scl_lo_nxt = 1'b1;
            sda_lo_nxt = (bit_r < 4'h8 && ph_r != LSM_P_RDATA) ?
                         !shf_r[7] : 1'b0;
          end
          2'h1: begin
          end
          2'h2: scl_lo_nxt = 1'b0;
          2'h3: begin
            if (bit_r < 4'h8) begin
              shf_nxt = {shf_r[6:0], sda_s};
              bit_nxt = 4'(bit_r + 4'h1);
            end else begin
              bit_nxt = 4'h0;
              if (ph_r == LSM_P_RDATA) begin
                rd_nxt = shf_r;
                st_nxt = LSM_H_STOP;
              end else if (sda_s) begin
                nack_nxt = 1'b1;
                st_nxt = LSM_H_STOP;
              end else begin
                unique case (ph_r)
                  LSM_P_DEVW: begin
                    ph_nxt = LSM_P_REG;
                    shf_nxt = addr_r;
                  end
                  LSM_P_REG: begin
                    if (wr_r) begin
                      ph_nxt = LSM_P_WDATA;
                      shf_nxt = wd_r;
                    end else begin
                      ph_nxt = LSM_P_DEVR;
                      st_nxt = LSM_H_START;
                    end
                  end
                  LSM_P_WDATA: st_nxt = LSM_H_STOP;
                  LSM_P_DEVR: ph_nxt = LSM_P_RDATA;
                  default: st_nxt = LSM_H_STOP;
                endcase
              end
            end
          end
        endcase
      end
      LSM_H_STOP: if (tick) begin
        unique case (q_r)
          2'h0: begin
            scl_lo_nxt = 1'b1;
            sda_lo_nxt = 1'b1;
          end
          2'h1: scl_lo_nxt = 1'b0;
          2'h2: sda_lo_nxt = 1'b0;
          2'h3: begin
            st_nxt = LSM_H_IDLE;
            done_nxt = 1'b1;
          end
        endcase
      end
    endcase
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= LSM_H_IDLE;
      ph_r <= LSM_P_DEVW;
      div_r <= '0;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      shf_r <= 8'h00;
      addr_r <= 8'h00;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
      wr_r <= 1'b0;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      scl_lo_r <= scl_lo_nxt;
      sda_lo_r <= sda_lo_nxt;
      nack_r <= nack_nxt;
      done_r <= done_nxt;
    end
  end
  // open-drain drives: only ever pull low
  assign LINK.host_scl_out = 1'b0;
  assign LINK.host_scl_oe = scl_lo_r;
  assign LINK.host_sda_out = 1'b0;
  assign LINK.host_sda_oe = sda_lo_r;
  assign CMD_BUSY_OUT = (st_r != LSM_H_IDLE);
  assign CMD_DONE_OUT = done_r;
  assign CMD_NACK_OUT = nack_r;
  assign CMD_RDATA_OUT = rd_r;
endmodule

// [tb/lsm_link_props.sv]
// Purpose: link checks between host and module ends
// Assumes: one clock domain, reset async active low
// Notes: watches resolved wires and module-side drives
`timescale 1ns/100ps
module lsm_link_props #(
  parameter int RST_MIN_CYC = 4,
  parameter int INIT_CYC = 8
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic scl,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic module_present_n,
  input wire logic interrupt_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic dev_int_out
);
  localparam int LONG_CYC = RST_MIN_CYC + 6;
  localparam int INIT_MAX = INIT_CYC + 16;
  logic [15:0] lo_cnt_r, lo_cnt_nxt, up_cnt_r, up_cnt_nxt;
  // low run of module reset and cycles since power-up
  always_comb begin
    lo_cnt_nxt = module_reset_n ? 16'h0000 : lo_cnt_r + 16'h0001;
    up_cnt_nxt = up_cnt_r + {15'h0000, up_cnt_r != 16'hFFFF};
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lo_cnt_r <= 16'h0000;
      up_cnt_r <= 16'h0000;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
      up_cnt_r <= up_cnt_nxt;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_present_low: assert property (!module_present_n)
    else $error("presence line not low");
  a_int_pull_only: assert property (!dev_int_out)
    else $error("interrupt driven high");
  a_sda_pull_only: assert property (dev_sda_oe |-> !dev_sda_out)
    else $error("data driven high");
  a_unsel_silent: assert property (
    module_select_n [*5] |-> !dev_sda_oe)
    else $error("unselected module drives data");
  a_sda_scl_low: assert property (
    $changed(dev_sda_oe) && !module_select_n |-> !scl)
    else $error("data changed with clock high");
  a_init_quiet: assert property (
    up_cnt_r < INIT_CYC |-> interrupt_n)
    else $error("interrupt before init ends");
  a_init_done: assert property (
    up_cnt_r == INIT_MAX |-> !interrupt_n)
    else $error("no power-up interrupt");
  a_short_ignored: assert property (
    !interrupt_n && !module_reset_n && module_select_n &&
    lo_cnt_r < RST_MIN_CYC |=> !interrupt_n)
    else $error("short reset cleared flags");
  a_long_clears: assert property (
    lo_cnt_r == LONG_CYC |-> interrupt_n)
    else $error("long reset kept interrupt");
  a_reinit_irq: assert property (
    $rose(module_reset_n) && lo_cnt_r >= LONG_CYC |->
    interrupt_n [*4] ##[1:INIT_MAX] !interrupt_n)
    else $error("no completion interrupt");
endmodule

// [tb/tb_module_lowspeed_mgmt_ctrl.sv]
// Purpose: end-to-end bench of host and module ends
// Assumes: both ends on one 200 MHz clock
// Notes: a second module shares the bus, never selected
`timescale 1ns/100ps
module tb_module_lowspeed_mgmt_ctrl;
  localparam int RST_MIN = 4;
  localparam int INIT = 8;
  logic clk, rst_n, fault, req, wr, sel, rreq, lp;
  logic [7:0] addr, wdata, rdata, cap_r, first_r;
  logic busy, done, nack, rdy, phe, mrst, pres, irq, sval;
  logic prev_scl_r = 1'h1;
  logic prev_sda_r = 1'h1;
  logic dev2_drove = 1'h0;
  int bit_n = 8;
  int num_errors = 0;
  int num_checks = 0;
  lsm_if link ();
  lsm_if link2 ();
  // second bus copy: same wires, own select held high
  assign link2.host_scl_out = link.host_scl_out;
  assign link2.host_scl_oe = link.host_scl_oe;
  assign link2.host_sda_out = 1'h0;
  assign link2.host_sda_oe = link.host_sda_oe ||
    (link.dev_sda_oe && !link.dev_sda_out);
  assign link2.module_select_n = 1'h1;
  assign link2.module_reset_n = link.module_reset_n;
  assign link2.low_power_select = link.low_power_select;
  lsm_device #(.RST_MIN_CYC(RST_MIN), .INIT_CYC(INIT)) lsm_device_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link), .FAULT_IN(fault),
    .READY_OUT(rdy), .POWER_HIGH_EN_OUT(phe), .MOD_RESET_OUT(mrst));
  lsm_device #(.RST_MIN_CYC(RST_MIN), .INIT_CYC(INIT)) lsm_device_b_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link2), .FAULT_IN(1'h0),
    .READY_OUT(), .POWER_HIGH_EN_OUT(), .MOD_RESET_OUT());
  lsm_host lsm_host_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link), .CMD_REQ_IN(req),
    .CMD_WR_IN(wr), .CMD_ADDR_IN(addr), .CMD_WDATA_IN(wdata),
    .CMD_BUSY_OUT(busy), .CMD_DONE_OUT(done), .CMD_NACK_OUT(nack),
    .CMD_RDATA_OUT(rdata), .SELECT_IN(sel), .RESET_REQ_IN(rreq),
    .LOW_POWER_IN(lp), .PRESENT_OUT(pres), .IRQ_OUT(irq),
    .STATUS_VALID_OUT(sval));
  lsm_link_props #(.RST_MIN_CYC(RST_MIN), .INIT_CYC(INIT)) lsm_link_props_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .scl(link.scl),
    .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n),
    .module_present_n(link.module_present_n),
    .interrupt_n(link.interrupt_n), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe(link.dev_sda_oe), .dev_int_out(link.dev_int_out));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // first byte after each start, msb first; unselected drive
  always @(posedge clk) begin
    if (link.scl && prev_scl_r && prev_sda_r && !link.sda) begin
      bit_n <= 0;
    end else if (link.scl && !prev_scl_r && bit_n < 8) begin
      cap_r <= {cap_r[6:0], link.sda};
      bit_n <= bit_n + 1;
      if (bit_n == 7) first_r <= {cap_r[6:0], link.sda};
    end
    prev_scl_r <= link.scl;
    prev_sda_r <= link.sda;
    if (link2.dev_sda_oe === 1'h1) dev2_drove <= 1'h1;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task automatic give_up(input string msg);
    chk(1'h0, msg);
    end_of_test();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one host command, waits for its done pulse
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk) #1 req = 1'h1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk) #1 req = 1'h0;
    chk(busy === 1'h1, "busy not raised");
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'h1 && n < 3000);
    if (done !== 1'h1) give_up("command hang");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cmd(1'h0, a, 8'h00);
    chk(rdata === e && nack === 1'h0, "read data");
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (irq !== 1'h1) give_up("no interrupt");
  endtask
  task automatic t_power_up();
    wait_irq();
    chk(rdy === 1'h1 && link.interrupt_n === 1'h0, "ready irq");
    chk(pres === 1'h1 && link.module_present_n === 1'h0, "pres");
    rd(8'h00, 8'h02);
    cycles(4);
    chk(irq === 1'h0 && link.interrupt_n === 1'h1, "irq stuck");
    $display("test power_up done");
  endtask
  task automatic t_rw();
    cmd(1'h1, 8'h05, 8'hA5);
    chk(nack === 1'h0 && first_r === 8'hA0, "write addr");
    chk(link.scl === 1'h1 && link.sda === 1'h1, "bus idle");
    rd(8'h05, 8'hA5);
    chk(first_r === 8'hA1, "read addr");
    cmd(1'h1, 8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    chk(dev2_drove === 1'h0, "unselected answered");
    $display("test rw done");
  endtask
  task automatic t_low_power();
    @(posedge clk) #1 lp = 1'h1;
    cycles(6);
    chk(link.low_power_select === 1'h1 && phe === 1'h0, "pin");
    @(posedge clk) #1 lp = 1'h0;
    cycles(6);
    chk(phe === 1'h1, "full power");
    cmd(1'h1, 8'h01, 8'h01);
    cycles(4);
    chk(phe === 1'h0, "ctrl cap");
    $display("test low_power done");
  endtask
  task automatic t_fault_short();
    @(posedge clk) #1 fault = 1'h1;
    @(posedge clk) #1 fault = 1'h0;
    wait_irq();
    @(posedge clk) #1 rreq = 1'h1;
    @(posedge clk);
    @(posedge clk) #1 rreq = 1'h0;
    repeat (12) begin
      @(negedge clk);
      chk(mrst === 1'h0, "short reset taken");
    end
    chk(irq === 1'h1, "flag lost");
    rd(8'h00, 8'h04);
    rd(8'h05, 8'hA5);
    $display("test fault_short done");
  endtask
  task automatic t_long_reset();
    @(posedge clk) #1 rreq = 1'h1;
    cycles(20);
    chk(mrst === 1'h1 && rdy === 1'h0, "reset active");
    chk(sval === 1'h0 && link.interrupt_n === 1'h1, "status");
    cmd(1'h0, 8'h05, 8'h00);
    chk(nack === 1'h1, "answered in reset");
    @(posedge clk) #1 rreq = 1'h0;
    wait_irq();
    cycles(2);
    chk(rdy === 1'h1 && sval === 1'h1, "status back");
    rd(8'h00, 8'h02);
    rd(8'h05, 8'h00);
    chk(phe === 1'h1, "ctrl default");
    $display("test long_reset done");
  endtask
  initial begin
    rst_n = 1'h0;
    fault = 1'h0;
    req = 1'h0;
    wr = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    sel = 1'h0;
    rreq = 1'h0;
    lp = 1'h0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
    t_power_up();
    t_rw();
    t_low_power();
    t_fault_short();
    t_long_reset();
    end_of_test();
  end
endmodule
